/* pkwi_map.svh */
`ifndef PKWI_MAP_SVH
`define PKWI_MAP_SVH

// Register indices; byte address is four times the index
`define PKWI_IDX_STATUS     16'h000C
`define PKWI_IDX_ENABLE     16'h000D

// Status and control field positions
`define PKWI_BIT_MODE       0
`define PKWI_BIT_MASK       1
`define PKWI_BIT_ACK        2
`define PKWI_BIT_FLAG       3

// Reset values
`define PKWI_RST_STATUS     8'h00
`define PKWI_RST_ENABLE     8'h00

// Service vector pair fetched by the processor
`define PKWI_VEC_HI         16'hFFEA
`define PKWI_VEC_LO         16'hFFEB

`endif

/* pkwi_pkg.sv */
`default_nettype none

package pkwi_pkg;

    // Bus slave handshake states
    typedef enum logic [1:0] {
        PKWI_BUS_IDLE = 2'h1,
        PKWI_BUS_DONE = 2'h2
    } pkwi_bus_state_type;

endpackage : pkwi_pkg

`default_nettype wire

/* pkwi_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pkwi_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_q
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule : pkwi_sync

`default_nettype wire

/* pkwi_request.sv */
`timescale 1ns/1ps
`default_nettype none

module pkwi_request #(
    parameter int PINS = 8
) (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst_b,
    // Pins and control
    input  wire logic [PINS-1:0] pin_level,
    input  wire logic [PINS-1:0] enable,
    input  wire logic            mode,
    input  wire logic            ack,
    // Request state
    output logic                 falling,
    output logic                 any_low,
    output logic                 latch_q,
    output logic                 pending_q
);

    logic all_high;
    logic prev_all_high_q;
    logic latch_d;

    // Disabled pins count as high
    assign all_high = &(pin_level | ~enable);
    assign any_low  = ~all_high;
    // Edge only when every enabled pin was high
    assign falling  = prev_all_high_q & any_low;
    // Set wins over a simultaneous acknowledge
    assign latch_d  = falling | (latch_q & ~ack);

    // Cleared low so a pin held low through reset raises nothing
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prev_all_high_q <= 1'b0;
        end else begin
            prev_all_high_q <= all_high;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Level mode holds the request while any enabled pin is low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= latch_d | (mode & any_low);
        end
    end

endmodule : pkwi_request

`default_nettype wire

/* pkwi_top.sv */
// Summary of operation
// - Each of eight enable bits makes its pin a keypad request source.
// - An enabled pin has its internal pull-up switched on.
// - Request latches when enabled pins go low after all were high.
// - Edge mode ignores a falling pin while another enabled pin is low.
// - Level mode holds the request while any enabled pin stays low.
// - Level mode clears only after acknowledge and all enabled pins high, any order.
// - A vector fetch acknowledges and clears the latched request.
// - Writing 1 to the acknowledge bit acknowledges; it reads as 0.
// - A falling edge after a software acknowledge latches a new request.
// - Unmasked request interrupts the processor, vector at fixed pair.
// - Edge mode clears at once on acknowledge, whatever the pins.
// - Reset clears request and trigger mode, even with a pin low.
// - Pending flag shows the request, unaffected by the mask.
// - Enable bit forces its pin to input over the direction bit.
// - Mask bit 1 blocks the request from the processor; reset clears.
// - Trigger mode 1 selects edge plus level, 0 edge only.
// - Status register bits 7 to 4 read as zero.
// - Reset clears the enable register and the pending flag.
// - Status at one address, enable at the next; both reset to zero.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pkwi_map.svh"

module pkwi_top #(
    parameter int ADDR_W = 8,
    parameter int PINS   = 8
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Keypad pins
    input  wire logic [PINS-1:0]   keypad_input_pin,
    output logic      [PINS-1:0]   pullup_enable,
    output logic      [PINS-1:0]   pin_force_input,
    // Processor interrupt
    input  wire logic              vector_fetch,
    output logic                   irq_request
);

    localparam logic [ADDR_W-1:0] ADDR_STATUS =
        ADDR_W'(4 * `PKWI_IDX_STATUS);
    localparam logic [ADDR_W-1:0] ADDR_ENABLE =
        ADDR_W'(4 * `PKWI_IDX_ENABLE);
    // Named so each field takes exactly its own reset bit
    localparam logic [7:0]        RST_STATUS  = `PKWI_RST_STATUS;

    logic                        rst_meta_q;
    logic                        rst_sync_b;
    pkwi_pkg::pkwi_bus_state_type bus_state_q;
    logic                        wait_q;
    logic [31:0]                 readdata_q;
    logic [PINS-1:0]             enable_q;
    logic                        mask_q;
    logic                        mode_q;
    logic                        irq_q;
    logic [PINS-1:0]             pin_sync;
    logic                        falling;
    logic                        any_low;
    logic                        latch_q;
    logic                        pending_q;
    logic                        bus_req;
    logic                        bus_taken;
    logic                        wr_commit;
    logic                        wr_status;
    logic                        wr_enable;
    logic                        sw_ack;
    logic                        ack;
    logic [7:0]                  status_view;
    logic [31:0]                 read_value;

    // Reset assert is immediate, release is clocked in
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_b <= rst_meta_q;
        end
    end

    // Pins come from outside the clock domain
    pkwi_sync #(
        .WIDTH    (PINS)
    ) u_pin_sync (
        .clock    (clock),
        .rst_b    (rst_sync_b),
        .async_in (keypad_input_pin),
        .sync_q   (pin_sync)
    );

    // Request core
    pkwi_request #(
        .PINS      (PINS)
    ) u_request (
        .clock     (clock),
        .rst_b     (rst_sync_b),
        .pin_level (pin_sync),
        .enable    (enable_q),
        .mode      (mode_q),
        .ack       (ack),
        .falling   (falling),
        .any_low   (any_low),
        .latch_q   (latch_q),
        .pending_q (pending_q)
    );

    assign bus_req   = avs_read | avs_write;
    assign bus_taken = bus_req & (bus_state_q == pkwi_pkg::PKWI_BUS_IDLE);
    // Writes land on the edge where waitrequest is seen low
    assign wr_commit = avs_write & avs_byteenable[0] &
                       (bus_state_q == pkwi_pkg::PKWI_BUS_DONE);
    assign wr_status = wr_commit & (avs_address == ADDR_STATUS);
    assign wr_enable = wr_commit & (avs_address == ADDR_ENABLE);

    // Acknowledge is a pulse, never stored
    assign sw_ack = wr_status & avs_writedata[`PKWI_BIT_ACK];
    assign ack    = sw_ack | vector_fetch;

    // Upper bits and acknowledge read as zero
    always_comb begin
        status_view                 = 8'h00;
        status_view[`PKWI_BIT_FLAG] = pending_q;
        status_view[`PKWI_BIT_MASK] = mask_q;
        status_view[`PKWI_BIT_MODE] = mode_q;
    end

    // Unmapped addresses read zero and ignore writes
    always_comb begin
        if (avs_address == ADDR_STATUS) begin
            read_value = {24'h00_0000, status_view};
        end else if (avs_address == ADDR_ENABLE) begin
            read_value = {24'h00_0000, 8'(enable_q)};
        end else begin
            read_value = 32'h0000_0000;
        end
    end

    // One wait cycle for every access
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bus_state_q <= pkwi_pkg::PKWI_BUS_IDLE;
            wait_q      <= 1'b1;
        end else begin
            case (bus_state_q)
                pkwi_pkg::PKWI_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_q <= pkwi_pkg::PKWI_BUS_DONE;
                        wait_q      <= 1'b0;
                    end
                end
                pkwi_pkg::PKWI_BUS_DONE: begin
                    bus_state_q <= pkwi_pkg::PKWI_BUS_IDLE;
                    wait_q      <= 1'b1;
                end
                default: begin
                    bus_state_q <= pkwi_pkg::PKWI_BUS_IDLE;
                    wait_q      <= 1'b1;
                end
            endcase
        end
    end

    // Read data captured when taken, stable while waitrequest is low
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            readdata_q <= 32'h0000_0000;
        end else if (bus_taken & avs_read) begin
            readdata_q <= read_value;
        end
    end

    // Enable register
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            enable_q <= PINS'(`PKWI_RST_ENABLE);
        end else if (wr_enable) begin
            enable_q <= avs_writedata[PINS-1:0];
        end
    end

    // Mask and trigger mode
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mask_q <= RST_STATUS[`PKWI_BIT_MASK];
            mode_q <= RST_STATUS[`PKWI_BIT_MODE];
        end else if (wr_status) begin
            mask_q <= avs_writedata[`PKWI_BIT_MASK];
            mode_q <= avs_writedata[`PKWI_BIT_MODE];
        end
    end

    // Processor fetches its vector from the fixed pair on this request
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= pending_q & ~mask_q;
        end
    end

    assign avs_readdata    = readdata_q;
    assign avs_waitrequest = wait_q;
    // Pull-up and input override follow the enable bits
    assign pullup_enable   = enable_q;
    assign pin_force_input = enable_q;
    assign irq_request     = irq_q;

    property p_enable_pullup;
        @(posedge clock) disable iff (!rst_sync_b)
        wr_enable |=> pullup_enable == $past(avs_writedata[PINS-1:0])
                      && pin_force_input == pullup_enable;
    endproperty
    a_enable_pullup: assert property (p_enable_pullup)
        else $error("pull-up does not follow enable write");

    property p_fall_sets;
        @(posedge clock) disable iff (!rst_sync_b)
        falling |=> pending_q;
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("falling edge did not raise the request");

    property p_edge_blocked;
        @(posedge clock) disable iff (!rst_sync_b)
        !mode_q && !latch_q && !falling |=> !pending_q;
    endproperty
    a_edge_blocked: assert property (p_edge_blocked)
        else $error("edge mode raised a request without an edge");

    property p_level_holds;
        @(posedge clock) disable iff (!rst_sync_b)
        mode_q && any_low |=> pending_q;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("level mode dropped request while a pin is low");

    property p_level_clear;
        @(posedge clock) disable iff (!rst_sync_b)
        mode_q && latch_q && !ack |=> pending_q;
    endproperty
    a_level_clear: assert property (p_level_clear)
        else $error("level request cleared without acknowledge");

    property p_edge_ack_clears;
        @(posedge clock) disable iff (!rst_sync_b)
        !mode_q && ack && !falling |=> !pending_q;
    endproperty
    a_edge_ack_clears: assert property (p_edge_ack_clears)
        else $error("edge mode acknowledge did not clear request");

    property p_ack_reads_zero;
        @(posedge clock) disable iff (!rst_sync_b)
        bus_taken && avs_read && avs_address == ADDR_STATUS
            |=> avs_readdata[`PKWI_BIT_ACK] == 1'b0
                && avs_readdata[7:4] == 4'h0;
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("acknowledge or upper status bits read nonzero");

    property p_irq_follows;
        @(posedge clock) disable iff (!rst_sync_b)
        irq_request == ($past(pending_q) && !$past(mask_q));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt does not follow request and mask");

    property p_flag_read;
        @(posedge clock) disable iff (!rst_sync_b)
        bus_taken && avs_read && avs_address == ADDR_STATUS
            |=> avs_readdata[`PKWI_BIT_FLAG] == $past(pending_q);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("pending flag read differs from request");

    property p_bus_answer;
        @(posedge clock) disable iff (!rst_sync_b)
        bus_taken |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not given in one wait cycle");

    property p_mode_write;
        @(posedge clock) disable iff (!rst_sync_b)
        wr_status |=> mode_q == $past(avs_writedata[`PKWI_BIT_MODE])
                      && mask_q == $past(avs_writedata[`PKWI_BIT_MASK]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode or mask did not take the written value");

    property p_level_release;
        @(posedge clock) disable iff (!rst_sync_b)
        mode_q && !latch_q && !falling && !any_low |=> !pending_q;
    endproperty
    a_level_release: assert property (p_level_release)
        else $error("level request held after acknowledge and release");

    property p_unmapped_read;
        @(posedge clock) disable iff (!rst_sync_b)
        bus_taken && avs_read && avs_address != ADDR_STATUS
            && avs_address != ADDR_ENABLE
            |=> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped address read nonzero");

    property p_mask_blocks;
        @(posedge clock) disable iff (!rst_sync_b)
        mask_q |=> !irq_request;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked request reached the processor");

    property p_cov_edge_irq;
        @(posedge clock) disable iff (!rst_sync_b)
        !mode_q && falling ##2 irq_request;
    endproperty
    c_cov_edge_irq: cover property (p_cov_edge_irq);

    property p_cov_level_any_order;
        @(posedge clock) disable iff (!rst_sync_b)
        mode_q && any_low && ack ##1 pending_q ##[1:50] !any_low;
    endproperty
    c_cov_level_any_order: cover property (p_cov_level_any_order);

    property p_cov_sw_ack;
        @(posedge clock) disable iff (!rst_sync_b)
        pending_q && sw_ack ##1 !pending_q;
    endproperty
    c_cov_sw_ack: cover property (p_cov_sw_ack);

    property p_cov_masked_poll;
        @(posedge clock) disable iff (!rst_sync_b)
        mask_q && pending_q && bus_taken && avs_read;
    endproperty
    c_cov_masked_poll: cover property (p_cov_masked_poll);

endmodule : pkwi_top

`default_nettype wire

/* pkwi_keypad_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pkwi_keypad_model (
    // Clock
    input  wire logic       clock,
    // Key presses and device pull-ups
    input  wire logic [7:0] key_pressed,
    input  wire logic [7:0] pullup_enable,
    // Port outputs driven high before enabling
    input  wire logic [7:0] drive_high,
    // Pin levels seen by the device
    output logic      [7:0] keypad_input_pin
);
    // Floating pins change every cycle, never a settled guess
    logic [7:0] float_q = 8'h5a;

    always_ff @(posedge clock) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (key_pressed[i]) begin
                keypad_input_pin[i] = 1'b0;
            end else if (pullup_enable[i]) begin
                keypad_input_pin[i] = 1'b1;
            end else if (drive_high[i]) begin
                keypad_input_pin[i] = 1'b1;
            end else begin
                keypad_input_pin[i] = float_q[i];
            end
        end
    end
endmodule : pkwi_keypad_model

`default_nettype wire

/* tb_port_keypad_wakeup_interrupt.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pkwi_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_port_keypad_wakeup_interrupt;
    localparam logic [7:0] A_ST = 8'(`PKWI_IDX_STATUS * 4);
    localparam logic [7:0] A_EN = 8'(`PKWI_IDX_ENABLE * 4);
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  pins;
    logic [7:0]  pullup_enable;
    logic [7:0]  pin_force_input;
    logic        vector_fetch = 1'b0;
    logic        irq_request;
    logic [7:0]  keys = 8'h00;
    logic [7:0]  drv_high = 8'h00;
    logic [7:0]  en_val;
    logic [31:0] rd;
    int          seed = 32'h2671_849b;
    int          errors = 0;
    int          cmp_count = 0;
    // Reference state, kept in plain integers
    int          pend, acknowledge_bit, m_mode, m_mask, m_en, m_low;

    pkwi_top pkwi_top_i (
        .clock(clock), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .keypad_input_pin(pins), .pullup_enable(pullup_enable),
        .pin_force_input(pin_force_input), .vector_fetch(vector_fetch),
        .irq_request(irq_request));

    pkwi_keypad_model pkwi_keypad_model_i (
        .clock(clock), .key_pressed(keys), .drive_high(drv_high),
        .pullup_enable(pullup_enable), .keypad_input_pin(pins));

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        @(posedge clock);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        // Only the watchdog ends a wait that never answers
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic do_ack();
        if (m_mode == 0 || m_low == 0) pend = 0;
        else acknowledge_bit = 1;
    endtask : do_ack

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        r = $random(seed);
        bus(1'b1, a, {r[31:8], d}, 4'hF);
        if (a == A_EN) begin
            m_en = d;
            m_low = keys & d;
        end
        if (a == A_ST) begin
            m_mode = d[0];
            m_mask = d[1];
            if (d[2]) do_ack();
        end
    endtask : wr

    task automatic vfetch();
        @(posedge clock);
        vector_fetch <= 1'b1;
        @(posedge clock);
        vector_fetch <= 1'b0;
        do_ack();
    endtask : vfetch

    task automatic set_keys(input logic [7:0] k);
        int nl;
        @(posedge clock);
        keys <= k;
        repeat (6) @(posedge clock);
        nl = k & m_en;
        if (nl != 0 && m_low == 0) begin
            pend = 1;
            acknowledge_bit = 0;
        end
        if (m_mode != 0 && nl == 0 && acknowledge_bit != 0) pend = 0;
        m_low = nl;
    endtask : set_keys

    task automatic chk();
        repeat (3) @(posedge clock);
        bus(1'b0, A_ST, 32'h0, 4'hF);
        `CHK(rd, 32'(pend * 8 + m_mask * 2 + m_mode))
        `CHK(irq_request, 1'(pend != 0 && m_mask == 0))
    endtask : chk

    task automatic do_reset();
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (5) @(posedge clock);
        {pend, acknowledge_bit, m_mode, m_mask, m_en, m_low} = '0;
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        give_verdict();
    end

    initial begin
        en_val = 8'($random(seed)) | 8'h03;
        do_reset();
        chk();
        bus(1'b0, A_EN, 32'h0, 4'hF);
        `CHK(rd, 32'h0000_0000)
        bus(1'b1, A_EN, 32'h0000_00FF, 4'h0);
        bus(1'b0, 8'h38, 32'h0, 4'hF);
        `CHK(rd, 32'h0000_0000)
        bus(1'b0, A_EN, 32'h0, 4'hF);
        `CHK(rd, 32'h0000_0000)
        $display("test reset done");
        wr(A_ST, 8'h02);
        wr(A_EN, en_val);
        repeat (6) @(posedge clock);
        wr(A_ST, 8'hF6);
        chk();
        wr(A_ST, 8'h00);
        bus(1'b0, A_EN, 32'h0, 4'hF);
        `CHK(rd, {24'h0, en_val})
        `CHK(pullup_enable, en_val)
        `CHK(pin_force_input, en_val)
        $display("test init done");
        set_keys(8'h01);
        chk();
        wr(A_ST, 8'h04);
        chk();
        set_keys(8'h03);
        chk();
        set_keys(8'h00);
        set_keys(8'h02);
        chk();
        vfetch();
        chk();
        set_keys(8'h00);
        wr(A_ST, 8'h04);
        set_keys(8'h02);
        chk();
        set_keys(8'h00);
        vfetch();
        $display("test edge done");
        wr(A_ST, 8'h02);
        set_keys(8'h01);
        chk();
        wr(A_ST, 8'h00);
        chk();
        set_keys(8'h00);
        wr(A_ST, 8'h04);
        $display("test mask done");
        wr(A_ST, 8'h01);
        chk();
        set_keys(8'h01);
        wr(A_ST, 8'h05);
        chk();
        set_keys(8'h00);
        chk();
        set_keys(8'h02);
        set_keys(8'h00);
        chk();
        vfetch();
        chk();
        $display("test level done");
        wr(A_ST, 8'h00);
        set_keys(8'h01);
        wr(A_ST, 8'h04);
        wr(A_EN, en_val & 8'hFE);
        set_keys(8'h03);
        chk();
        set_keys(8'h00);
        wr(A_EN, en_val);
        repeat (6) @(posedge clock);
        wr(A_ST, 8'h04);
        set_keys(8'h01);
        wr(A_ST, 8'h01);
        chk();
        do_reset();
        chk();
        `CHK(pullup_enable, 8'h00)
        $display("test pin release and reset done");
        set_keys(8'h00);
        drv_high <= en_val;
        repeat (3) @(posedge clock);
        wr(A_EN, en_val);
        chk();
        $display("test output guard done");
        give_verdict();
    end
endmodule : tb_port_keypad_wakeup_interrupt

`default_nettype wire
